// File: hdl/clear_flag.v
/*
  Holds one clear-only status flag with read-then-write-zero clearing.
  Assumes the caller supplies a one-cycle set pulse, a read strobe and a
  write-zero strobe, all on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module clear_flag #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire core_clk,
  input  wire arst_n,
  input  wire clk_en,
  // Events.
  input  wire set_pulse,
  input  wire force_set,
  input  wire rd_strobe,
  input  wire wr_zero,
  // State.
  output reg  flag_q
);

  reg armed_q;  // Software has read this flag as one.

  // Flag with set winning over the clear, and force holding it high.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_q  <= RESET_VAL;
      armed_q <= 1'b0;
    end else if (clk_en) begin
      if (force_set || set_pulse) begin
        flag_q <= 1'b1;
      end else if (wr_zero && armed_q) begin
        flag_q <= 1'b0;
      end
      // Only an actual read of one arms the clear; a write-zero strobe always disarms.
      if (wr_zero) begin
        armed_q <= 1'b0;
      end else if (rd_strobe) begin
        armed_q <= flag_q;
      end
    end
  end

endmodule
`default_nettype wire

// File: hdl/serial_status_defs.vh
/*
  Holds the constants of the serial status flag block: register offsets,
  field positions and reset values.
  Assumes inclusion by bare name from the design files of this block.
*/
// Overview of operation
// - Buffer-empty sets when buffer moves to shifter.
// - Transmit disabled forces buffer-empty and transmit-end high.
// - Buffer-empty clears by read-one then write-zero.
// - Buffer-full sets on error-free reception completion.
// - Buffer-full clears only by read-one-write-zero.
// - Receive disable leaves buffer-full unchanged.
// - Overrun sets when character completes while full.
// - Framing error on zero first stop bit.
// - Parity error sets on failed parity check; the code does not set it while skip mode is on.
// - Transmit-end sets at last bit while empty.
// - Received multiprocessor bit captured, kept when disabled.
// - Transmit multiprocessor bit is software read/write.
// - Writing one never sets a clear-only flag.
// - Skip mode drops frames with multiprocessor bit zero.
`ifndef SERIAL_STATUS_DEFS_VH
`define SERIAL_STATUS_DEFS_VH
`define ADDR_STATUS       4'h0
`define ADDR_CONTROL      4'h4
`define ADDR_IRQ_STATUS   4'h8
`define ADDR_IRQ_MASK     4'hC
`define BIT_TDE           7
`define BIT_RBF           6
`define BIT_OVR           5
`define BIT_FRM           4
`define BIT_PAR           3
`define BIT_TX_END        2
`define BIT_RMP           1
`define BIT_TMP           0
`define CTL_TX_EN         0
`define CTL_RX_EN         1
`define CTL_SKIP_EN       2
`define STATUS_RESET      8'h84
`define CONTROL_RESET     8'h00
`define IRQ_RESET         8'h00
`endif

// File: hdl/serial_status_flags.v
/*
  Holds the status flag logic of one serial channel with a classic
  Wishbone slave, event status, mask and an interrupt output.
  Assumes the shift engines give one-cycle strobes on core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "serial_status_defs.vh"
module serial_status_flags (
  // Clock, enable and reset.
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       clk_en,
  // Wishbone slave.
  input  wire       wb_cyc_i,
  input  wire       wb_stb_i,
  input  wire       wb_we_i,
  input  wire [3:0] wb_adr_i,
  input  wire [3:0] wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg        wb_ack_o,
  // Transmit engine.
  input  wire       tx_load,
  input  wire       tx_last_bit,
  output reg        tx_multiproc_bit,
  output reg        transmit_enable,
  // Receive engine.
  input  wire       rx_done,
  input  wire       rx_frame_err,
  input  wire       rx_parity_err,
  input  wire       rx_mp_in,
  output reg        receive_enable,
  // Interrupt.
  output reg        irq
);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire       req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;  // New access.
  wire       lane0   = wb_sel_i[0];                      // Low byte lane.
  wire       wr      = req & wb_we_i & lane0;            // Write strobe.
  wire       rd      = req & ~wb_we_i;                   // Read strobe.
  wire       st_sel  = (wb_adr_i == `ADDR_STATUS);       // Status hit.
  wire       st_rd   = rd & st_sel;                      // Status read.
  wire       st_wr   = wr & st_sel;                      // Status write.
  wire [7:0] wd      = wb_dat_i[7:0];                    // Write byte.

  reg        skip_q;     // Multiprocessor skip enable.
  reg        tx_end_q;   // Transmit end.
  reg        tde_armed_q;  // Software has read buffer-empty as one.
  reg        rmp_q;      // Received multiprocessor bit.
  reg  [7:0] ev_q;       // Sticky interrupt status.
  reg  [7:0] mask_q;     // Interrupt mask.

  ////////////////////////////////////////////////////////////////////////
  // Receive qualification.

  // A frame whose multiprocessor bit is zero is dropped in skip mode.
  // Nothing here clears buffer-full when reception is disabled.
  wire rx_take   = rx_done & receive_enable & ~(skip_q & ~rx_mp_in);
  wire rx_ok     = rx_take & ~rx_frame_err & ~rx_parity_err;
  wire [7:0] flags;  // Clear-only flag values.

  // Full set only on clean completion with the buffer free.
  wire set_rbf = rx_ok & ~flags[`BIT_RBF];
  wire set_ovr = rx_take & flags[`BIT_RBF];
  wire set_frm = rx_take & rx_frame_err;
  wire set_par = rx_take & rx_parity_err & ~skip_q;
  wire set_tde = tx_load & transmit_enable;
  wire tx_off  = ~transmit_enable;

  ////////////////////////////////////////////////////////////////////////
  // Clear-only flags, one instance per bit 7 down to 3.

  wire [7:3] set_v   = {set_tde, set_rbf, set_ovr, set_frm, set_par};
  wire [7:3] force_v = {tx_off, 4'h0};
  genvar gi;
  generate
    for (gi = 3; gi < 8; gi = gi + 1) begin : g_flag
      // Data bit one is ignored here; only zero can clear.
      clear_flag #(
        .RESET_VAL (gi == `BIT_TDE)
      ) u_flag (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .set_pulse (set_v[gi]),
        .force_set (force_v[gi]),
        .rd_strobe (st_rd),
        .wr_zero   (st_wr & ~wd[gi]),
        .flag_q    (flags[gi])
      );
    end
  endgenerate
  assign flags[2:0] = 3'h0;

  // Arms like buffer-empty on a status read but disarms on any status write, so transmit end clears with it if the next status write has bit 7 zero.
  // A local copy avoids reaching into the flag instance by hierarchy.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tde_armed_q <= 1'b0;
    end else if (clk_en) begin
      if (st_wr) begin
        tde_armed_q <= 1'b0;  // Any status write disarms.
      end else if (st_rd) begin
        tde_armed_q <= flags[`BIT_TDE];  // Only a read of one arms.
      end
    end
  end

  wire [7:0] status = {flags[7:3], tx_end_q, rmp_q, tx_multiproc_bit};

  ////////////////////////////////////////////////////////////////////////
  // Transmit end, multiprocessor bits and control.

  // Transmit end follows buffer-empty and the last transmitted bit.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_end_q <= 1'b1;
    end else if (clk_en) begin
      if (tx_off) begin
        tx_end_q <= 1'b1;
      end else if (tx_last_bit && flags[`BIT_TDE]) begin
        tx_end_q <= 1'b1;
      end else if (st_wr && !wd[`BIT_TDE] && tde_armed_q) begin
        tx_end_q <= 1'b0;
      end
    end
  end

  // Multiprocessor bits and control register.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rmp_q            <= 1'b0;
      tx_multiproc_bit <= 1'b0;
      transmit_enable  <= 1'b0;
      receive_enable   <= 1'b0;
      skip_q           <= 1'b0;
    end else if (clk_en) begin
      // Capture only while enabled, so disabling keeps the value.
      if (rx_done && receive_enable) begin
        rmp_q <= rx_mp_in;
      end
      if (st_wr) begin
        tx_multiproc_bit <= wd[`BIT_TMP];
      end
      if (wr && wb_adr_i == `ADDR_CONTROL) begin
        transmit_enable <= wd[`CTL_TX_EN];
        receive_enable  <= wd[`CTL_RX_EN];
        skip_q          <= wd[`CTL_SKIP_EN];
      end else if (rx_take && skip_q) begin
        skip_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  wire [7:0] ev_in = {set_tde, set_rbf, set_ovr, set_frm, set_par,
                      tx_last_bit & flags[`BIT_TDE], 2'h0};
  wire       ev_rd = rd & (wb_adr_i == `ADDR_IRQ_STATUS);

  // Events stick; a read clears, but a new event in that cycle wins.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ev_q   <= `IRQ_RESET;
      mask_q <= `IRQ_RESET;
      irq    <= 1'b0;
    end else if (clk_en) begin
      ev_q <= (ev_rd ? 8'h00 : ev_q) | ev_in;
      if (wr && wb_adr_i == `ADDR_IRQ_MASK) begin
        mask_q <= wd;
      end
      irq <= |(ev_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: ack registered one cycle after the request, zero for unmapped addresses.

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= req;
      if (rd) begin
        case (wb_adr_i)
          `ADDR_STATUS:     wb_dat_o <= {24'h000000, status};
          `ADDR_CONTROL:    wb_dat_o <= {29'h0, skip_q, receive_enable, transmit_enable};
          `ADDR_IRQ_STATUS: wb_dat_o <= {24'h000000, ev_q};
          `ADDR_IRQ_MASK:   wb_dat_o <= {24'h000000, mask_q};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/serial_line_model.sv
/* Line-side model of the shift engines feeding the status flags.
   Assumes the bench calls its tasks just after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module serial_line_model (
  // Clock.
  input  wire logic core_clk,
  // Engine strobes; qualifiers are invalid outside rx_done.
  output var  logic rx_done = 1'b0,
  output var  logic rx_frame_err = 1'b1,
  output var  logic rx_parity_err = 1'b1,
  output var  logic rx_mp_in = 1'b1,
  output var  logic tx_load = 1'b0,
  output var  logic tx_last_bit = 1'b0
);
  // One received character; qualifiers invert once the strobe ends.
  task automatic rx_char(input logic fe, input logic pe, input logic mp);
    @(posedge core_clk);
    rx_done <= 1'b1;
    rx_frame_err <= fe;
    rx_parity_err <= pe;
    rx_mp_in <= mp;
    @(posedge core_clk);
    rx_done <= 1'b0;
    rx_frame_err <= ~fe;
    rx_parity_err <= ~pe;
    rx_mp_in <= ~mp;
  endtask
  // A buffer load when ld is high, else the last bit of a character.
  task automatic tx_pulse(input logic ld);
    @(posedge core_clk);
    tx_load <= ld;
    tx_last_bit <= ~ld;
    @(posedge core_clk);
    tx_load <= 1'b0;
    tx_last_bit <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/serial_status_chk.sv
/* Checker for the serial status flag block.
   Assumes a bind to serial_status_flags with clk_en and wb_sel_i high. */
`timescale 1ns/10ps
`default_nettype none
module serial_status_chk (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        arst_n,
  // Bus and flag outputs.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tx_multiproc_bit,
  input wire logic        transmit_enable,
  input wire logic        receive_enable,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Answer to a read of the status register.
  wire logic st_rd = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits set");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_tx_off_flags: assert property (st_rd && !$past(transmit_enable)
    && !$past(transmit_enable, 2) |-> wb_dat_o[7] && wb_dat_o[2]) else $error("tx flags");
  a_tx_mp_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h0
    |=> tx_multiproc_bit == $past(wb_dat_i[0])) else $error("tx mp bit");
  a_enable_write: assert property (wb_ack_o && wb_we_i && wb_adr_i == 4'h4
    |=> {receive_enable, transmit_enable} == $past(wb_dat_i[1:0])) else $error("enables");
  c_status_full: cover property (st_rd && wb_dat_o[6]);
  c_rx_on: cover property (receive_enable && st_rd);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/* Self-checking bench for the serial status flag block.
   Assumes the line model drives the engine strobes. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, we = 1'b0, ack, tx_en, rx_en, irq;
  logic done, fe, pe, mp, ld, last, tx_mp;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, r;
  logic [15:0] exp_q[$];
  int failures = 0, cmp_count = 0;
  always #2 clk = ~clk;
  serial_status_flags i_dut (.core_clk(clk), .arst_n(arst_n), .clk_en(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_load(ld), .tx_last_bit(last), .rx_done(done),
    .tx_multiproc_bit(tx_mp), .transmit_enable(tx_en), .rx_frame_err(fe),
    .rx_parity_err(pe), .rx_mp_in(mp), .receive_enable(rx_en), .irq(irq));
  serial_line_model i_line (.core_clk(clk), .rx_done(done), .rx_frame_err(fe),
    .rx_parity_err(pe), .rx_mp_in(mp), .tx_load(ld), .tx_last_bit(last));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
    cmp_count++;
    if ((g & m) !== (e & m)) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict;
    $display("Compares %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One classic cycle; held until ack is seen, released at that edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    logic [31:0] rn;
    rn = $urandom;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {rn[23:0], d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t no ack", $time);
      print_verdict();
    end
    cyc <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    cmp({7'h0, irq}, {7'h0, e}, 8'h01);
  endtask
  // Read answers are matched against the oldest expectation.
  always @(negedge clk) if (ack === 1'b1 && !we && exp_q.size() > 0) begin
    cmp(rdat[7:0], exp_q[0][7:0], exp_q[0][15:8]);
    void'(exp_q.pop_front());
  end
  initial begin
    r = $urandom(11687);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(4'h0, 8'h84);
    rd(4'h4, 8'h00);
    rd(4'h2, 8'h00);
    repeat (4) begin
      r = $urandom;
      bus(1'b1, 4'h0, r[7:0]);
      rd(4'h0, 8'h84 | {7'h0, r[0]});
    end
    bus(1'b1, 4'h0, 8'h00);
    $display("Test reset done");
    bus(1'b1, 4'h4, 8'h01);
    rd(4'h0, 8'h84);
    bus(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'h00);
    i_line.tx_pulse(1'b1);
    rd(4'h0, 8'h80);
    i_line.tx_pulse(1'b0);
    rd(4'h0, 8'h84);
    bus(1'b1, 4'h0, 8'h00);
    i_line.tx_pulse(1'b0);
    rd(4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h00);
    rd(4'h0, 8'h84);
    $display("Test transmit done");
    bus(1'b1, 4'h4, 8'h02);
    i_line.rx_char(1'b0, 1'b0, 1'b1);
    rd(4'h0, 8'hC6);
    bus(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'h86);
    i_line.rx_char(1'b0, 1'b0, 1'b0);
    bus(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'hC4);
    i_line.rx_char(1'b0, 1'b0, 1'b1);
    rd(4'h0, 8'hE4, 8'hE4);
    bus(1'b1, 4'h4, 8'h00);
    rd(4'h0, 8'h40, 8'h40);
    bus(1'b1, 4'h0, 8'h00);
    rd(4'h0, 8'h84, 8'hFD);
    bus(1'b1, 4'h4, 8'h02);
    i_line.rx_char(1'b1, 1'b0, 1'b1);
    rd(4'h0, 8'h94, 8'hFD);
    bus(1'b1, 4'h0, 8'h00);
    i_line.rx_char(1'b0, 1'b1, 1'b1);
    rd(4'h0, 8'h8C, 8'hFD);
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b1, 4'h4, 8'h06);
    i_line.rx_char(1'b1, 1'b0, 1'b0);
    rd(4'h0, 8'h84, 8'hFD);
    i_line.rx_char(1'b0, 1'b0, 1'b1);
    rd(4'h4, 8'h02);
    $display("Test receive done");
    bus(1'b1, 4'hC, 8'hFC);
    rd(4'h8, 8'h00, 8'h00);
    chk_irq(1'b0);
    i_line.rx_char(1'b0, 1'b0, 1'b0);
    chk_irq(1'b1);
    rd(4'h8, 8'h20);
    chk_irq(1'b0);
    bus(1'b1, 4'hC, 8'h00);
    i_line.rx_char(1'b0, 1'b0, 1'b0);
    chk_irq(1'b0);
    $display("Test interrupt done");
    print_verdict();
  end
endmodule
bind serial_status_flags serial_status_chk i_chk (.core_clk(core_clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq),
  .tx_multiproc_bit(tx_multiproc_bit), .transmit_enable(transmit_enable),
  .receive_enable(receive_enable));
`default_nettype wire
